// ===== ebot_pkg.sv
// package of constants and types for the eight bit overflow timer
package ebot_pkg;

	// ==========================================================
	// register bus
	localparam int ADDR_W = 8;
	localparam int DATA_W = 8;
	localparam logic [7:0] OFS_CONTROL = 8'h00;
	localparam logic [7:0] OFS_COUNT = 8'h01;
	localparam logic [7:0] OFS_IRQ_MASK = 8'h02;
	localparam logic [7:0] OFS_IRQ_FLAGS = 8'h03;
	localparam logic [7:0] READ_IDLE = 8'h00;

	// ==========================================================
	// field positions
	localparam int CS_LSB = 0;
	localparam int CS_W = 3;
	localparam int OVF_BIT = 0;
	localparam int OVF_IE_BIT = 0;

	// ==========================================================
	// reset values
	localparam logic [2:0] RST_CLK_SEL = 3'h0;
	localparam logic [7:0] RST_COUNT = 8'h00;
	localparam logic [7:0] RST_IRQ_MASK = 8'h00;
	localparam logic RST_OVF = 1'b0;

	// ==========================================================
	// counter limits
	localparam logic [7:0] CNT_MAX = 8'hff;
	localparam logic [7:0] CNT_STEP = 8'h01;

	// ==========================================================
	// prescaler: tap k fires when its low bits are all ones
	localparam int PRE_W = 10;
	localparam int TAP_NUM = 5;
	localparam int TAP_LOG2 [0:TAP_NUM-1] = '{0, 3, 6, 8, 10};
	localparam logic [9:0] RST_PRE = 10'h000;

	// ==========================================================
	// clock source selections, in field code order
	typedef enum logic [2:0] {
		CS_STOP,
		CS_DIV1,
		CS_DIV8,
		CS_DIV64,
		CS_DIV256,
		CS_DIV1024,
		CS_EXT_FALL,
		CS_EXT_RISE
	} ebot_clk_sel_t;

	// ==========================================================
	// carriers and state
	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic wr;
		logic rd;
	} ebot_bus_req_t;

	typedef struct packed {
		logic [2:0] clk_sel;
		logic [7:0] count;
		logic [7:0] irq_mask;
		logic ovf;
		logic [7:0] rdata;
	} ebot_regs_t;

	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
	} ebot_sync_t;

endpackage

// ===== ebot_prescaler.sv
// free running prescaler shared by both timers
`timescale 1ns/1ns
module ebot_prescaler
	import ebot_pkg::*;
(
	// clock and reset
	input wire logic ref_clk_in,
	input wire logic reset_n_in,
	// control
	input wire logic pre_clear_in,
	// taps
	output logic [TAP_NUM-1:0] taps_out
);

	// ==========================================================
	// state
	logic [PRE_W-1:0] cnt_r;
	logic [PRE_W-1:0] cnt_nxt;

	function automatic logic tap_hit(input logic [PRE_W-1:0] c, input int n);
		logic [PRE_W-1:0] m;
		m = PRE_W'((32'd1 << n) - 32'd1);
		return (c & m) == m;
	endfunction

	// ==========================================================
	// counter: runs whatever any timer selects
	always_comb begin
		cnt_nxt = cnt_r + PRE_W'(1);
		if (pre_clear_in) begin
			cnt_nxt = RST_PRE;
		end
	end

	always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			cnt_r <= RST_PRE;
		end else begin
			cnt_r <= cnt_nxt;
		end
	end

	// ==========================================================
	// taps: one cycle pulses except tap 0, which is high every cycle; first 2^n - 1 cycles after any start
	always_comb begin
		for (int k = 0; k < TAP_NUM; k++) begin
			taps_out[k] = tap_hit(cnt_r, TAP_LOG2[k]);
		end
	end

endmodule // ebot_prescaler

// ===== ebot_ext_sync.sv
// synchroniser and edge detector for the external count input
`timescale 1ns/1ns
module ebot_ext_sync
	import ebot_pkg::*;
(
	// clock and reset
	input wire logic ref_clk_in,
	input wire logic reset_n_in,
	// pin
	input wire logic pin_in,
	// edge pulses
	output logic rise_out,
	output logic fall_out
);

	// ==========================================================
	// state
	ebot_sync_t st_r;
	ebot_sync_t st_nxt;

	// s1 feeds only s2; edges compare s2 with s3
	always_comb begin
		st_nxt = st_r;
		st_nxt.s1 = pin_in;
		st_nxt.s2 = st_r.s1;
		st_nxt.s3 = st_r.s2;
	end

	always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	// ==========================================================
	// edges; a pulse narrower than a cycle may be missed
	assign rise_out = st_r.s2 & ~st_r.s3;
	assign fall_out = ~st_r.s2 & st_r.s3;

endmodule // ebot_ext_sync

// ===== ebot_timer.sv
// eight bit up counter with overflow flag and register port
//
// Chosen here: the register offsets and the address-and-strobe port.
`timescale 1ns/1ns
module ebot_timer
	import ebot_pkg::*;
(
	// clock and reset
	input wire logic ref_clk_in,
	input wire logic reset_n_in,
	// register port
	input wire ebot_bus_req_t bus_req_in,
	output logic [DATA_W-1:0] rdata_out,
	// external count pin
	input wire logic ext_count_in,
	// processor interrupt handshake
	input wire logic global_irq_enable_in,
	input wire logic irq_vector_ack_in,
	output logic irq_out,
	// shared prescaler
	input wire logic prescaler_clear_in,
	output logic [TAP_NUM-1:0] prescale_taps_out,
	// status
	output logic [7:0] count_out,
	output logic overflow_flag_out,
	output logic timer_tick_out
);

	// ==========================================================
	// state and helpers
	ebot_regs_t st_r;
	ebot_regs_t st_nxt;
	logic [TAP_NUM-1:0] taps;
	logic ext_rise;
	logic ext_fall;
	logic timer_tick;
	logic wr_control;
	logic wr_count;
	logic wr_mask;
	logic wr_flags;
	logic ovf_set;
	logic ovf_clr;

	function automatic logic hit(input ebot_bus_req_t q, input logic [7:0] ofs);
		return q.addr == ofs;
	endfunction

	// ==========================================================
	// shared prescaler
	ebot_prescaler u_pre (
		.ref_clk_in(ref_clk_in),
		.reset_n_in(reset_n_in),
		.pre_clear_in(prescaler_clear_in),
		.taps_out(taps)
	);

	// other timer picks its own tap from the same taps
	assign prescale_taps_out = taps;

	// ==========================================================
	// external pin; its level is taken from the pad, so an
	// output-driven pin still counts
	ebot_ext_sync u_ext (
		.ref_clk_in(ref_clk_in),
		.reset_n_in(reset_n_in),
		.pin_in(ext_count_in),
		.rise_out(ext_rise),
		.fall_out(ext_fall)
	);

	// ==========================================================
	// tick select; changing select while the pin moves may
	// give one false tick
	always_comb begin
		case (ebot_clk_sel_t'(st_r.clk_sel))
			CS_STOP: begin
				timer_tick = 1'b0;
			end
			CS_DIV1: begin
				timer_tick = taps[0];
			end
			CS_DIV8: begin
				timer_tick = taps[1];
			end
			CS_DIV64: begin
				timer_tick = taps[2];
			end
			CS_DIV256: begin
				timer_tick = taps[3];
			end
			CS_DIV1024: begin
				timer_tick = taps[4];
			end
			CS_EXT_FALL: begin
				timer_tick = ext_fall;
			end
			CS_EXT_RISE: begin
				timer_tick = ext_rise;
			end
			default: begin
				timer_tick = 1'b0;
			end
		endcase
	end

	// ==========================================================
	// write decode
	always_comb begin
		wr_control = bus_req_in.wr && hit(bus_req_in, OFS_CONTROL);
		wr_count = bus_req_in.wr && hit(bus_req_in, OFS_COUNT);
		wr_mask = bus_req_in.wr && hit(bus_req_in, OFS_IRQ_MASK);
		wr_flags = bus_req_in.wr && hit(bus_req_in, OFS_IRQ_FLAGS);
	end

	// ==========================================================
	// flag events
	always_comb begin
		// a written count discards the tick, so no overflow
		ovf_set = timer_tick && (st_r.count == CNT_MAX) && !wr_count;
		ovf_clr = (wr_flags && bus_req_in.wdata[OVF_BIT])
			|| irq_vector_ack_in;
	end

	// ==========================================================
	// next state
	always_comb begin
		st_nxt = st_r;
		// counter
		if (timer_tick) begin
			st_nxt.count = st_r.count + CNT_STEP;
		end
		if (wr_count) begin
			st_nxt.count = bus_req_in.wdata;
		end
		// control and mask
		if (wr_control) begin
			st_nxt.clk_sel = bus_req_in.wdata[CS_LSB +: CS_W];
		end
		if (wr_mask) begin
			st_nxt.irq_mask = bus_req_in.wdata;
		end
		// flag: clear first so a same-cycle set wins
		if (ovf_clr) begin
			st_nxt.ovf = 1'b0;
		end
		if (ovf_set) begin
			st_nxt.ovf = 1'b1;
		end
		// read data stands for one cycle only
		st_nxt.rdata = READ_IDLE;
		if (bus_req_in.rd) begin
			if (hit(bus_req_in, OFS_CONTROL)) begin
				st_nxt.rdata = {5'h00, st_r.clk_sel};
			end else if (hit(bus_req_in, OFS_COUNT)) begin
				st_nxt.rdata = st_r.count;
			end else if (hit(bus_req_in, OFS_IRQ_MASK)) begin
				st_nxt.rdata = st_r.irq_mask;
			end else if (hit(bus_req_in, OFS_IRQ_FLAGS)) begin
				st_nxt.rdata = {7'h00, st_r.ovf};
			end else begin
				st_nxt.rdata = READ_IDLE;
			end
		end
	end

	// ==========================================================
	// registers
	always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			st_r.clk_sel <= RST_CLK_SEL;
			st_r.count <= RST_COUNT;
			st_r.irq_mask <= RST_IRQ_MASK;
			st_r.ovf <= RST_OVF;
			st_r.rdata <= READ_IDLE;
		end else begin
			st_r <= st_nxt;
		end
	end

	// ==========================================================
	// outputs
	assign rdata_out = st_r.rdata;
	assign count_out = st_r.count;
	assign overflow_flag_out = st_r.ovf;
	assign timer_tick_out = timer_tick;
	assign irq_out = global_irq_enable_in && st_r.irq_mask[OVF_IE_BIT] && st_r.ovf;

endmodule // ebot_timer

// ===== ebot_pulse_src.sv
// external pulse source driving the count pin
`timescale 1ns/1ns
module ebot_pulse_src (
	// clock and control
	input wire logic ref_clk_in,
	input wire logic run_in,
	input wire logic [3:0] half_in,
	// pin
	output logic pin_out
);
	// =======
	// toggles between edges; half period is half_in+2 cycles, never one
	int n = 0;
	logic pin_r = 1'b0;
	// moves on the falling edge, well clear of the sampling edge
	always @(negedge ref_clk_in) begin
		if (!run_in) begin
			n <= 0;
		end else if (n > half_in) begin
			n <= 0;
			pin_r <= !pin_r;
		end else begin
			n <= n + 1;
		end
	end
	assign pin_out = pin_r;
endmodule // ebot_pulse_src

// ===== ebot_timer_asserts.sv
// port checker for the overflow timer
`timescale 1ns/1ns
module ebot_timer_asserts
	import ebot_pkg::*;
(
	// watched ports
	input wire logic ref_clk_in,
	input wire logic reset_n_in,
	input wire ebot_bus_req_t bus_req_in,
	input wire logic [DATA_W-1:0] rdata_out,
	input wire logic global_irq_enable_in,
	input wire logic irq_vector_ack_in,
	input wire logic irq_out,
	input wire logic [7:0] count_out,
	input wire logic overflow_flag_out,
	input wire logic timer_tick_out
);
	// =======
	default clocking @(posedge ref_clk_in); endclocking
	default disable iff (!reset_n_in);
	logic cw;
	logic fw;
	logic wrap;
	assign cw = bus_req_in.wr && bus_req_in.addr == OFS_COUNT;
	assign fw = bus_req_in.wr && bus_req_in.addr == OFS_IRQ_FLAGS && bus_req_in.wdata[0];
	assign wrap = timer_tick_out && count_out == CNT_MAX && !cw;
	property p_inc;
		timer_tick_out && !cw |=> count_out == $past(count_out) + 8'h01;
	endproperty
	a_inc: assert property (p_inc) else $error("count step wrong");
	property p_hold;
		!timer_tick_out && !cw |=> $stable(count_out);
	endproperty
	a_hold: assert property (p_hold) else $error("count moved untimed");
	property p_wr;
		cw |=> count_out == $past(bus_req_in.wdata);
	endproperty
	a_wr: assert property (p_wr) else $error("count write lost");
	property p_set;
		wrap |=> overflow_flag_out;
	endproperty
	a_set: assert property (p_set) else $error("flag not set on wrap");
	property p_keep;
		overflow_flag_out && !irq_vector_ack_in && !fw |=> overflow_flag_out;
	endproperty
	a_keep: assert property (p_keep) else $error("flag dropped");
	property p_rise;
		$rose(overflow_flag_out) |-> $past(wrap);
	endproperty
	a_rise: assert property (p_rise) else $error("flag set without wrap");
	property p_clr;
		(irq_vector_ack_in || fw) && !wrap |=> !overflow_flag_out;
	endproperty
	a_clr: assert property (p_clr) else $error("flag not cleared");
	property p_irq;
		irq_out |-> global_irq_enable_in && overflow_flag_out;
	endproperty
	a_irq: assert property (p_irq) else $error("stray interrupt");
	property p_rd;
		bus_req_in.rd && bus_req_in.addr == OFS_COUNT |=> rdata_out == $past(count_out);
	endproperty
	a_rd: assert property (p_rd) else $error("count read wrong");
	property p_idle;
		!bus_req_in.rd |=> rdata_out == READ_IDLE;
	endproperty
	a_idle: assert property (p_idle) else $error("read data not idle");
	c_wrap: cover property (wrap);
	c_ack: cover property (irq_vector_ack_in && overflow_flag_out);
	c_irq: cover property (irq_out);
endmodule // ebot_timer_asserts

bind ebot_timer ebot_timer_asserts chk_u (.ref_clk_in, .reset_n_in, .bus_req_in, .rdata_out,
	.global_irq_enable_in, .irq_vector_ack_in, .irq_out, .count_out, .overflow_flag_out,
	.timer_tick_out);

// ===== ebot_timer_test.sv
// self-checking bench for the overflow timer
`timescale 1ns/1ns
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin bad_count++; \
	$display("BAD t=%0t got %h exp %h", $time, a, e); end end
module ebot_timer_test
	import ebot_pkg::*;
();
	// =======
	logic ref_clk_in = 1'b0;
	logic reset_n_in = 1'b0;
	ebot_bus_req_t req = '0;
	logic gie = 1'b0, ack = 1'b0, pclr = 1'b0, run = 1'b0;
	logic [3:0] half = 4'h0;
	logic pin, flag, irq, tick;
	logic [7:0] rdata, count, d, v;
	logic [TAP_NUM-1:0] taps;
	int bad_count = 0, num_checks = 0, rises = 0, falls = 0;
	always #25 ref_clk_in = !ref_clk_in;
	always @(posedge pin) rises++;
	always @(negedge pin) falls++;
	ebot_timer dut_u (.ref_clk_in, .reset_n_in, .bus_req_in(req), .rdata_out(rdata),
		.ext_count_in(pin), .global_irq_enable_in(gie), .irq_vector_ack_in(ack),
		.irq_out(irq), .prescaler_clear_in(pclr), .prescale_taps_out(taps),
		.count_out(count), .overflow_flag_out(flag), .timer_tick_out(tick));
	ebot_pulse_src src_u (.ref_clk_in, .run_in(run), .half_in(half), .pin_out(pin));
	function automatic int div_of(int k);
		int t[6] = '{0, 1, 8, 64, 256, 1024};
		return t[k];
	endfunction
	task automatic bw(input logic [7:0] a, input logic [7:0] x);
		@(posedge ref_clk_in) req <= '{a, x, 1'b1, 1'b0};
		@(posedge ref_clk_in) req <= '0;
	endtask
	task automatic br(input logic [7:0] a, output logic [7:0] x);
		@(posedge ref_clk_in) req <= '{a, 8'h00, 1'b0, 1'b1};
		@(posedge ref_clk_in) req <= '0;
		@(negedge ref_clk_in) x = rdata;
	endtask
	task automatic cr(input logic [7:0] a, input logic [7:0] e);
		br(a, d);
		`CHK(d, e)
	endtask
	// settle to mid-cycle after n more edges
	task automatic nx(input int n);
		repeat (n) @(posedge ref_clk_in);
		@(negedge ref_clk_in);
	endtask
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	initial begin
		#(50 * 20000);
		bad_count++;
		report_and_stop;
	end
	initial begin
		void'($urandom(25091));
		repeat (10) @(posedge ref_clk_in);
		reset_n_in <= 1'b1;
		for (int i = 0; i < 5; i++) cr(8'(i), 8'h00);
		`CHK(tick, 1'b0)
		v = 8'($urandom);
		bw(OFS_IRQ_MASK, v);
		cr(OFS_IRQ_MASK, v);
		v = 8'($urandom);
		bw(OFS_COUNT, v);
		bw(OFS_CONTROL, 8'hf8);
		cr(OFS_CONTROL, 8'h00);
		cr(OFS_COUNT, v);
		bw(OFS_COUNT, 8'hfe);
		bw(OFS_CONTROL, 8'h01);
		nx(2);
		`CHK(count, 8'h00)
		`CHK(flag, 1'b1)
		bw(OFS_COUNT, 8'h40);
		nx(0);
		`CHK(count, 8'h40)
		bw(OFS_IRQ_FLAGS, 8'h00);
		cr(OFS_IRQ_FLAGS, 8'h01);
		bw(OFS_IRQ_MASK, 8'h01);
		@(posedge ref_clk_in) gie <= 1'b1;
		nx(0);
		`CHK(irq, 1'b1)
		@(posedge ref_clk_in) gie <= 1'b0;
		nx(0);
		`CHK(irq, 1'b0)
		@(posedge ref_clk_in) ack <= 1'b1;
		@(posedge ref_clk_in) ack <= 1'b0;
		nx(0);
		`CHK(flag, 1'b0)
		bw(OFS_COUNT, 8'hff);
		nx(1);
		`CHK(flag, 1'b1)
		bw(OFS_IRQ_FLAGS, 8'h01);
		nx(0);
		`CHK(flag, 1'b0)
		// second write lands in the wrap cycle: written value wins, no overflow
		bw(OFS_COUNT, 8'hfe);
		bw(OFS_COUNT, 8'h55);
		nx(0);
		`CHK(count, 8'h55)
		`CHK(flag, 1'b0)
		// flag clear lands in the wrap cycle: the set wins
		bw(OFS_COUNT, 8'hfe);
		bw(OFS_IRQ_FLAGS, 8'h01);
		nx(0);
		`CHK(flag, 1'b1)
		bw(OFS_CONTROL, 8'h00);
		br(OFS_COUNT, v);
		repeat (20) @(posedge ref_clk_in);
		cr(OFS_COUNT, v);
		// window is a little over two periods after the prescaler clear, so two land; the check allows two or three
		for (int k = 2; k < 6; k++) begin
			bw(OFS_COUNT, 8'h00);
			@(posedge ref_clk_in) pclr <= 1'b1;
			@(posedge ref_clk_in) pclr <= 1'b0;
			nx(0);
			`CHK(taps, 5'h01)
			bw(OFS_CONTROL, 8'(k));
			repeat (2 * div_of(k)) @(posedge ref_clk_in);
			bw(OFS_CONTROL, 8'h00);
			br(OFS_COUNT, d);
			`CHK(d inside {8'h02, 8'h03}, 1'b1)
		end
		for (int k = 6; k < 8; k++) begin
			bw(OFS_COUNT, 8'h00);
			bw(OFS_CONTROL, 8'(k));
			rises = 0;
			falls = 0;
			half <= 4'($urandom_range(9));
			run <= 1'b1;
			repeat (200) @(posedge ref_clk_in);
			run <= 1'b0;
			repeat (4) @(posedge ref_clk_in);
			br(OFS_COUNT, d);
			`CHK(d, 8'(k == 7 ? rises : falls))
		end
		report_and_stop;
	end
endmodule // ebot_timer_test
